// ==== hdl/host_control_pkg.sv ====
// Purpose: types shared by the run-state block
// Assumes: nothing
// Notes:   offsets and counts live in host_control_regs.svh
package host_control_pkg;

    // ======================================================================
    // register port request
    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    // ======================================================================
    // list-walker decision request and answer
    typedef enum logic [2:0] {
        ASK_NONE,
        ASK_PERIODIC,
        ASK_ISO,
        ASK_NONPERIODIC,
        ASK_CONTROL_DONE
    } list_ask_t;

    typedef struct packed {
        logic servePeriodic;
        logic continueIso;
        logic serveControl;
        logic serveBulk;
    } list_grant_t;

endpackage

// ==== hdl/host_control_regs.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the run-state block
// Assumes: 100 MHz clock, registers reached by a word-wide port at printed offsets
// Notes:   definitions only
`ifndef HOST_CONTROL_REGS_SVH
`define HOST_CONTROL_REGS_SVH

// ==========================================================================
// register map
`define HOST_CONTROL_OFFSET   8'h04
`define EVENT_STATUS_OFFSET   8'h0c

// ==========================================================================
// field positions
`define RATIO_LSB             0
`define PERIODIC_ON_BIT       2
`define ISO_ON_BIT            3
`define CONTROL_ON_BIT        4
`define BULK_ON_BIT           5
`define RUN_STATE_LSB         6
`define FRAME_START_BIT       2

// ==========================================================================
// reset values and codes
`define HOST_CONTROL_RESET    8'h00
`define RUN_BUS_RESET         2'h0
`define RUN_RESUME            2'h1
`define RUN_RUNNING           2'h2
`define RUN_SUSPENDED         2'h3

// ==========================================================================
// timing
`define CLOCK_MHZ             100
`define SOF_DELAY_US          1000
`define SOF_DELAY_CYCLES      (`SOF_DELAY_US * `CLOCK_MHZ)
`define PORT_RESET_US         10
`define PORT_RESET_CYCLES     (`PORT_RESET_US * `CLOCK_MHZ)

`endif

// ==== hdl/host_run_state_and_list_enables.sv ====
// Purpose: low byte of the host control register: run state, list enables, service ratio
// Assumes: word-wide register port synchronous to clock; list walker asks one question a cycle
// Notes:   frame timing itself comes from outside through frameTick
`timescale 1ns/1ns
`default_nettype none
`include "host_control_regs.svh"

// Summary of operation
// - entering running state from another state starts frame packets one millisecond later
// - frame-start flag, bit 2 of event status, reports that frame packets began
// - hardware changes run state on its own only while suspended
// - resume signalling from a port while suspended moves run state to resume
// - software reset leaves run state at suspended
// - hardware reset puts run state in bus reset
// - hardware reset resets root hub then drives reset onto downstream ports
// - bulk enable serves bulk from next frame; cleared stops after next frame start; bulkOn_reg acts from the next question instead
// - bulk enable is sampled at each bulk attempt, not latched once per frame
// - control enable acts from next frame, stops after next start, checked per attempt; controlOn_reg acts from the next question instead
// - at an isochronous descriptor, iso enable clear abandons periodic list
// - setting iso enable takes effect next frame, never within current frame
// - periodic enable checked before periodic list, from next frame, skipped once cleared; periodicOn_reg acts from the next question instead
// - before each nonperiodic descriptor compare ratio with control served count
// - control served count keeps its value across frame boundaries
// - ratio code 00b means one control descriptor per bulk descriptor
// - run state lives in bits 7 to 6, code 00b is bus reset
module host_run_state_and_list_enables #(
    parameter int SOF_DELAY_CYCLES  = `SOF_DELAY_CYCLES,
    parameter int PORT_RESET_CYCLES = `PORT_RESET_CYCLES,
    parameter int PORT_COUNT        = 4
) (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          clockEnable,
    input  wire logic                          softReset,
    input  wire host_control_pkg::reg_req_t    regReq,
    output var  logic [31:0]                   regRdata,
    output var  logic                          regRvalid,
    input  wire logic                          frameStatusClear,
    input  wire logic                          frameTick,
    input  wire logic [PORT_COUNT-1:0]         portResumeDetect,
    input  wire host_control_pkg::list_ask_t   listAsk,
    input  wire logic                          controlNonEmpty,
    output var  host_control_pkg::list_grant_t listGrant,
    output var  logic                          sofEnable,
    output var  logic                          rootHubReset,
    output var  logic [PORT_COUNT-1:0]         portReset,
    output var  logic [1:0]                    runState
);
    import host_control_pkg::*;

    // run state and frame start
    logic [1:0] runState_next;
    logic       ctlWrite;
    logic       sofStart;
    logic       sofDone;
    logic       frameStart_reg;

    // list enables, service ratio and control served count
    logic       bulkOn_reg;
    logic       controlOn_reg;
    logic       periodicOn_reg;
    logic       isoOn_reg;
    logic       isoFrame_reg;
    logic [1:0] ratio_reg;
    logic [2:0] servedCount_reg;

    // hardware reset sequencing
    localparam int PRW = $clog2(PORT_RESET_CYCLES + 1);
    logic           portResetBusy_reg;
    logic           hubPhase_reg;
    logic [PRW-1:0] portCount_reg;

    // resume seen on any port
    logic       anyResume;

    // ======================================================================
    // decode helpers
    function automatic logic [2:0] ratio_limit(input logic [1:0] code);
        ratio_limit = {1'b0, code};
    endfunction

    function automatic logic hit(input reg_req_t r, input logic [7:0] off);
        hit = (r.addr == off);
    endfunction

    // write strobe and any-port resume
    assign ctlWrite  = regReq.write && hit(regReq, `HOST_CONTROL_OFFSET);
    assign anyResume = |portResumeDetect;

    // ======================================================================
    // run-state next value: driver writes, or resume while suspended
    always_comb begin
        runState_next = runState;
        if (ctlWrite) begin
            runState_next = regReq.wdata[`RUN_STATE_LSB +: 2];
        end else if (runState == `RUN_SUSPENDED && anyResume) begin
            runState_next = `RUN_RESUME;
        end
    end

    // entry to running from elsewhere starts the holdoff
    assign sofStart = (runState_next == `RUN_RUNNING) && (runState != `RUN_RUNNING);

    // ======================================================================
    // run state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            runState <= `RUN_BUS_RESET;
        end else if (clockEnable) begin
            if (softReset) begin
                runState <= `RUN_SUSPENDED;
            end else begin
                runState <= runState_next;
            end
        end
    end

    // ======================================================================
    // list enables; cleared on any reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bulkOn_reg     <= 1'b0;
            controlOn_reg  <= 1'b0;
            periodicOn_reg <= 1'b0;
            isoOn_reg      <= 1'b0;
        end else if (clockEnable) begin
            if (softReset) begin
                bulkOn_reg     <= 1'b0;
                controlOn_reg  <= 1'b0;
                periodicOn_reg <= 1'b0;
                isoOn_reg      <= 1'b0;
            end else if (ctlWrite) begin
                bulkOn_reg     <= regReq.wdata[`BULK_ON_BIT];
                controlOn_reg  <= regReq.wdata[`CONTROL_ON_BIT];
                periodicOn_reg <= regReq.wdata[`PERIODIC_ON_BIT];
                isoOn_reg      <= regReq.wdata[`ISO_ON_BIT];
            end
        end
    end

    // service ratio; lost on any reset, the driver writes it back
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ratio_reg <= 2'h0;
        end else if (clockEnable) begin
            if (softReset) begin
                ratio_reg <= 2'h0;
            end else if (ctlWrite) begin
                ratio_reg <= regReq.wdata[`RATIO_LSB +: 2];
            end
        end
    end

    // ======================================================================
    // iso enable as seen by this frame: a set waits for the frame tick, a clear acts now
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            isoFrame_reg <= 1'b0;
        end else if (clockEnable) begin
            if (frameTick) begin
                isoFrame_reg <= isoOn_reg;
            end else if (!isoOn_reg) begin
                isoFrame_reg <= 1'b0;
            end
        end
    end

    // ======================================================================
    // start-of-frame holdoff after entry to running
    sof_delay_timer #(
        .DELAY_CYCLES (SOF_DELAY_CYCLES)
    ) sofTimer (
        .clock       (clock),
        .rst_n       (rst_n),
        .clockEnable (clockEnable),
        .start       (sofStart && !softReset),
        .abort       (softReset || runState_next != `RUN_RUNNING),
        .done        (sofDone)
    );

    // frame generation enable follows the holdoff
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sofEnable <= 1'b0;
        end else if (clockEnable) begin
            if (softReset || runState_next != `RUN_RUNNING) begin
                sofEnable <= 1'b0;
            end else if (sofDone) begin
                sofEnable <= 1'b1;
            end
        end
    end

    // ======================================================================
    // frame-start flag: set wins over a write-one clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frameStart_reg <= 1'b0;
        end else if (clockEnable) begin
            if (sofDone || (sofEnable && frameTick)) begin
                frameStart_reg <= 1'b1;
            end else if (frameStatusClear) begin
                frameStart_reg <= 1'b0;
            end
        end
    end

    // ======================================================================
    // hardware reset: root hub first, then port reset signalling
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rootHubReset <= 1'b1;
            hubPhase_reg <= 1'b1;
        end else if (clockEnable) begin
            rootHubReset <= 1'b0;
            hubPhase_reg <= 1'b0;
        end
    end

    // port reset signalling follows as the root hub is released
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            portResetBusy_reg <= 1'b0;
            portCount_reg     <= '0;
            portReset         <= '0;
        end else if (clockEnable) begin
            if (hubPhase_reg) begin
                portResetBusy_reg <= 1'b1;
                portCount_reg     <= PRW'(PORT_RESET_CYCLES - 1);
                portReset         <= '1;
            end else if (portResetBusy_reg) begin
                if (portCount_reg == '0) begin
                    portResetBusy_reg <= 1'b0;
                    portReset         <= '0;
                end else begin
                    portCount_reg <= portCount_reg - 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // list decisions: enables sampled at each question; iso uses its per-frame copy, so a set waits for the frame tick
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            listGrant       <= '0;
            servedCount_reg <= 3'h0;
        end else if (clockEnable) begin
            listGrant <= '0;
            unique case (listAsk)
                ASK_NONE: begin
                end
                ASK_PERIODIC: begin
                    listGrant.servePeriodic <= periodicOn_reg && sofEnable;
                end
                ASK_ISO: begin
                    listGrant.continueIso <= isoFrame_reg;
                end
                ASK_NONPERIODIC: begin
                    if (controlOn_reg && controlNonEmpty &&
                        (servedCount_reg <= ratio_limit(ratio_reg) || !bulkOn_reg)) begin
                        listGrant.serveControl <= 1'b1;
                    end else if (bulkOn_reg) begin
                        listGrant.serveBulk <= 1'b1;
                        servedCount_reg     <= 3'h0;
                    end
                end
                ASK_CONTROL_DONE: begin
                    if (servedCount_reg <= ratio_limit(ratio_reg)) begin
                        servedCount_reg <= servedCount_reg + 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // register read port, one cycle latency
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdata  <= 32'h0000_0000;
            regRvalid <= 1'b0;
        end else if (clockEnable) begin
            regRvalid <= regReq.read;
            regRdata  <= 32'h0000_0000;
            if (regReq.read && hit(regReq, `HOST_CONTROL_OFFSET)) begin
                regRdata[7:0] <= {runState, bulkOn_reg, controlOn_reg,
                                  isoOn_reg, periodicOn_reg, ratio_reg};
            end else if (regReq.read && hit(regReq, `EVENT_STATUS_OFFSET)) begin
                regRdata[`FRAME_START_BIT] <= frameStart_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/sof_delay_timer.sv ====
// Purpose: counts the start-of-frame holdoff after entry to the running state
// Assumes: start is a one-cycle pulse
// Notes:   done pulses once when the count runs out
`timescale 1ns/1ns
`default_nettype none
module sof_delay_timer #(
    parameter int DELAY_CYCLES = 1000
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clockEnable,
    input  wire logic start,
    input  wire logic abort,
    output var  logic done
);
    localparam int W = $clog2(DELAY_CYCLES + 1);

    logic [W-1:0] count_reg;
    logic         busy_reg;

    // ======================================================================
    // countdown; abort wins, a fresh start restarts
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done      <= 1'b0;
        end else if (clockEnable) begin
            done <= 1'b0;
            if (abort) begin
                busy_reg <= 1'b0;
            end else if (start) begin
                count_reg <= W'(DELAY_CYCLES - 1);
                busy_reg  <= 1'b1;
            end else if (busy_reg) begin
                if (count_reg == '0) begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                end else begin
                    count_reg <= count_reg - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/host_run_state_and_list_enables_tb_top.sv ====
// Purpose: drives registers, frames, resume and list questions; compares with expectations
// Assumes: shortened frame delay and port reset counts
// Notes:   random register data from a fixed linear feedback register
`timescale 1ns/1ns
`default_nettype none
module host_run_state_and_list_enables_tb_top;
    import host_control_pkg::*;
    localparam int SOF_N = 20;
    localparam int PRT_N = 5;
    logic        clock = 1'b0, rst_n = 1'b0, clockEnable = 1'b1, softReset = 1'b0;
    logic        frameStatusClear = 1'b0, frameTick = 1'b0, controlNonEmpty = 1'b0;
    reg_req_t    regReq = '0;
    list_ask_t   listAsk = ASK_NONE;
    logic [3:0]  wake = 4'h0, portResumeDetect, portReset;
    logic [31:0] regRdata, lfsr = 32'h0001_0966;
    logic        regRvalid, sofEnable, rootHubReset;
    list_grant_t listGrant, g;
    logic [1:0]  runState;
    int          fail_count = 0, samples_checked = 0, n;

    // ======================================================================
    // block, port model and clock
    host_run_state_and_list_enables #(.SOF_DELAY_CYCLES(SOF_N), .PORT_RESET_CYCLES(PRT_N),
        .PORT_COUNT(4)) dut (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
        .softReset(softReset), .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
        .frameStatusClear(frameStatusClear), .frameTick(frameTick),
        .portResumeDetect(portResumeDetect), .listAsk(listAsk),
        .controlNonEmpty(controlNonEmpty), .listGrant(listGrant), .sofEnable(sofEnable),
        .rootHubReset(rootHubReset), .portReset(portReset), .runState(runState));
    resume_port_model ports (.clock(clock), .rst_n(rst_n), .wake(wake),
        .portReset(portReset), .portResumeDetect(portResumeDetect));
    always #5 clock = ~clock;

    // ======================================================================
    // helpers
    function automatic logic [31:0] nextLfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int ctlPerBulk(int code);
        return code + 1;
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic regWrite(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        regReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        regReq <= '0;
    endtask
    task automatic regCheck(logic [7:0] a, logic [31:0] exp);
        @(posedge clock);
        regReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clock);
        regReq <= '0;
        #1;
        check("read valid", {31'h0, regRvalid}, 32'h1);
        check("read data", regRdata, exp);
    endtask
    task automatic ask(list_ask_t k, logic ne);
        @(posedge clock);
        listAsk         <= k;
        controlNonEmpty <= ne;
        @(posedge clock);
        listAsk <= ASK_NONE;
        #1;
        g = listGrant;
    endtask
    task automatic tick();
        @(posedge clock);
        frameTick <= 1'b1;
        @(posedge clock);
        frameTick <= 1'b0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        check("hub release", {runState, rootHubReset, portReset}, 7'h0f);
        repeat (PRT_N) @(posedge clock);
        #1;
        check("port reset end", portReset, 4'h0);
        regCheck(8'h04, 32'h0);
        regCheck(8'h10, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lfsr = nextLfsr(lfsr);
            regWrite(8'h04, {lfsr[31:8], 2'b00, lfsr[5:0]});
            regCheck(8'h04, {26'h0, lfsr[5:0]});
        end
        $display("test reset and fields done");
        regWrite(8'h04, 32'h04);
        ask(ASK_PERIODIC, 1'b0);
        check("periodic idle", g, 4'h0);
        regWrite(8'h04, 32'h84);
        repeat (4) @(posedge clock);
        clockEnable <= 1'b0;
        repeat (3) @(posedge clock);
        clockEnable <= 1'b1;
        n = 7;
        while (sofEnable !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 200) begin
            fail_count++;
            test_done();
        end
        check("frame delay", n, SOF_N + 4);
        regCheck(8'h0c, 32'h4);
        ask(ASK_PERIODIC, 1'b0);
        check("periodic on", g, 4'h8);
        @(posedge clock);
        frameStatusClear <= 1'b1;
        @(posedge clock);
        frameStatusClear <= 1'b0;
        regCheck(8'h0c, 32'h0);
        regWrite(8'h04, 32'h80);
        ask(ASK_PERIODIC, 1'b0);
        check("periodic off", g, 4'h0);
        $display("test frame start done");
        regWrite(8'h04, 32'h88);
        ask(ASK_ISO, 1'b0);
        check("iso same frame", g, 4'h0);
        tick();
        ask(ASK_ISO, 1'b0);
        check("iso next frame", g, 4'h4);
        regWrite(8'h04, 32'h80);
        ask(ASK_ISO, 1'b0);
        check("iso cleared", g, 4'h0);
        $display("test iso done");
        for (int c = 0; c < 4; c++) begin
            regWrite(8'h04, 32'hb0 | c);
            for (int k = 0; k < ctlPerBulk(c); k++) begin
                ask(ASK_NONPERIODIC, 1'b1);
                check("control turn", g, 4'h2);
                ask(ASK_CONTROL_DONE, 1'b1);
                tick();
            end
            ask(ASK_NONPERIODIC, 1'b1);
            check("bulk turn", g, 4'h1);
        end
        regWrite(8'h04, 32'h80);
        ask(ASK_NONPERIODIC, 1'b1);
        check("lists off", g, 4'h0);
        regWrite(8'h04, 32'ha0);
        ask(ASK_NONPERIODIC, 1'b1);
        check("bulk only", g, 4'h1);
        $display("test ratio done");
        regWrite(8'h04, 32'hc0);
        @(posedge clock);
        wake <= 4'h4;
        @(posedge clock);
        wake <= 4'h0;
        n = 0;
        while (runState !== 2'h1 && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 20) begin
            fail_count++;
            test_done();
        end
        regCheck(8'h04, 32'h40);
        regWrite(8'h04, 32'hbf);
        @(posedge clock);
        softReset <= 1'b1;
        @(posedge clock);
        softReset <= 1'b0;
        #1;
        check("soft reset", {sofEnable, runState}, 3'h3);
        regCheck(8'h04, 32'hc0);
        $display("test suspend done");
        test_done();
    end
endmodule
`default_nettype wire

// ==== sim/host_run_state_properties.sv ====
// Purpose: checks run state, frame start timing and list grants at the block ports
// Assumes: one clock, reset asynchronous and active low
// Notes:   bound to the block below the module
`timescale 1ns/1ns
`default_nettype none
module host_run_state_properties
    import host_control_pkg::*;
#(
    parameter int SOF_DELAY_CYCLES  = 20,
    parameter int PORT_RESET_CYCLES = 5,
    parameter int PORT_COUNT        = 4
) (
    input wire logic                          clock,
    input wire logic                          rst_n,
    input wire logic                          clockEnable,
    input wire logic                          softReset,
    input wire host_control_pkg::reg_req_t    regReq,
    input wire logic [31:0]                   regRdata,
    input wire logic                          regRvalid,
    input wire logic                          frameStatusClear,
    input wire logic                          frameTick,
    input wire logic [PORT_COUNT-1:0]         portResumeDetect,
    input wire host_control_pkg::list_ask_t   listAsk,
    input wire logic                          controlNonEmpty,
    input wire host_control_pkg::list_grant_t listGrant,
    input wire logic                          sofEnable,
    input wire logic                          rootHubReset,
    input wire logic [PORT_COUNT-1:0]         portReset,
    input wire logic [1:0]                    runState
);
    // ======================================================================
    // enabled cycles spent in the running state, saturating past the delay
    int runCount;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            runCount <= 0;
        end else if (clockEnable) begin
            runCount <= (runState != 2'h2) ? 0 :
                        (runCount > SOF_DELAY_CYCLES) ? runCount : runCount + 1;
        end
    end

    // ======================================================================
    // properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence hubReleased;
        $fell(rootHubReset) && runState == 2'h0;
    endsequence
    sequence portsPulsed;
        portReset == '1 [*5] ##1 portReset == '0;
    endsequence
    AST_HW_RESET: assert property (hubReleased |-> portsPulsed)
        else $error("hub release did not pulse the port resets");
    AST_SOF_START: assert property ($rose(sofEnable) |-> runCount == SOF_DELAY_CYCLES + 1)
        else $error("frame packets began at the wrong time");
    AST_SOF_HOLD: assert property (
        runState == 2'h2 && runCount < SOF_DELAY_CYCLES |-> !sofEnable)
        else $error("frame packets began early");
    AST_SOF_STOP: assert property (runState != 2'h2 && $past(runState) != 2'h2 |-> !sofEnable)
        else $error("frame packets outside running");
    AST_OWN_CHANGE: assert property (
        $changed(runState) && !$past(regReq.write && clockEnable) && !$past(softReset)
        |-> $past(runState) == 2'h3 && runState == 2'h1)
        else $error("run state changed by itself outside suspend");
    AST_RESUME: assert property (
        runState == 2'h3 && |portResumeDetect && clockEnable && !softReset && !regReq.write
        |=> runState == 2'h1)
        else $error("resume signalling ignored");
    AST_SOFT_RESET: assert property (softReset && clockEnable |=> runState == 2'h3 && !sofEnable)
        else $error("software reset did not suspend");
    AST_PERIODIC: assert property (
        listGrant.servePeriodic |-> $past(listAsk) == ASK_PERIODIC && $past(sofEnable))
        else $error("periodic grant without cause");
    AST_NONPERIODIC: assert property (
        listGrant.serveControl || listGrant.serveBulk |-> $past(listAsk) == ASK_NONPERIODIC
        && !(listGrant.serveControl && listGrant.serveBulk)
        && (!listGrant.serveControl || $past(controlNonEmpty)))
        else $error("nonperiodic grant without cause");
endmodule
bind host_run_state_and_list_enables host_run_state_properties #(
    .SOF_DELAY_CYCLES(SOF_DELAY_CYCLES), .PORT_RESET_CYCLES(PORT_RESET_CYCLES),
    .PORT_COUNT(PORT_COUNT)
) chk (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable), .softReset(softReset),
    .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
    .frameStatusClear(frameStatusClear), .frameTick(frameTick),
    .portResumeDetect(portResumeDetect), .listAsk(listAsk), .controlNonEmpty(controlNonEmpty),
    .listGrant(listGrant), .sofEnable(sofEnable), .rootHubReset(rootHubReset),
    .portReset(portReset), .runState(runState));
`default_nettype wire

// ==== sim/resume_port_model.sv ====
// Purpose: downstream ports that signal resume some cycles after a wake request
// Assumes: wake is a one-cycle pulse naming the ports
// Notes:   a port held in reset never signals resume
`timescale 1ns/1ns
`default_nettype none
module resume_port_model #(
    parameter int LAG           = 2,
    parameter int RESUME_CYCLES = 4
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [3:0] wake,
    input  wire logic [3:0] portReset,
    output var  logic [3:0] portResumeDetect
);
    // ======================================================================
    // latch the waking ports and count the lag plus the resume window
    logic [3:0] pending;
    int         ticks;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 4'h0;
            ticks   <= 0;
        end else if (wake != 4'h0) begin
            pending <= wake & ~portReset;
            ticks   <= LAG + RESUME_CYCLES;
        end else if (ticks != 0) begin
            ticks <= ticks - 1;
        end
    end
    // resume level shows only inside its window
    assign portResumeDetect = (ticks != 0 && ticks <= RESUME_CYCLES) ? pending : 4'h0;
endmodule
`default_nettype wire
